// *** verification/flash_self_program_sequencer_bench.sv ***
// Purpose: directed bench for the flash sequencer
// Assumes: inputs change on the falling edge, the bench answers for the array
// Notes: latches start unknown, so every word checked is loaded first
`timescale 1ns/1ps
module flash_self_program_sequencer_bench;
   import flash_seq_pkg::*;
   logic clk_i = 0, rst_b_i = 0, tw_valid_i = 0, ctl_wr_i = 0, key_wr_i = 0;
   logic other_wr_i = 0, fl_done_i = 0, stall_o, tw_ack_o, fl_req_o;
   logic [15:0] tw_addr_i = 16'h0000, tblptr_i = 16'h0000, fl_addr_o;
   logic [15:0] ctl_data_i = 16'h0000, ctl_o;
   logic [23:0] tw_data_i = 24'h000000, fl_wdata_o;
   logic [7:0] key_data_i = 8'h00;
   logic [1:0] fl_op_o;
   logic [23:0] lat [64];
   int n_errors = 0, n_compared = 0, cyc = 0;
   flash_self_program_sequencer #(.ADDR_W(16)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .tw_valid_i(tw_valid_i), .tw_addr_i(tw_addr_i), .tw_data_i(tw_data_i),
      .ctl_wr_i(ctl_wr_i), .ctl_data_i(ctl_data_i), .key_wr_i(key_wr_i),
      .key_data_i(key_data_i), .other_wr_i(other_wr_i), .tblptr_i(tblptr_i),
      .ctl_o(ctl_o), .stall_o(stall_o), .tw_ack_o(tw_ack_o), .fl_req_o(fl_req_o),
      .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o),
      .fl_done_i(fl_done_i));
   initial forever #25 clk_i = ~clk_i;
   // a few hundred cycles are needed, so this only trips on a hang
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic nx();
      @(negedge clk_i);
   endtask
   // ack says whether the load is expected to be taken (false while busy)
   task automatic load(logic [5:0] a, logic [23:0] d, logic ack);
      tw_valid_i = 1;
      tw_addr_i = {10'h000, a};
      tw_data_i = d;
      if (ack) lat[a] = d;
      nx();
      tw_valid_i = 0;
      chk("tw_ack", tw_ack_o, ack);
      nx();
   endtask
   // kind 0 key, 1 control, 2 other write
   task automatic wr(int k, logic [15:0] v);
      key_wr_i = (k == 0);
      ctl_wr_i = (k == 1);
      other_wr_i = (k == 2);
      key_data_i = v[7:0];
      ctl_data_i = v;
      nx();
      {key_wr_i, ctl_wr_i, other_wr_i} = 3'h0;
      nx();
   endtask
   task automatic run(logic [15:0] c, logic [15:0] p, logic [15:0] b, int n);
      tblptr_i = p;
      wr(0, 16'h0055);
      wr(0, 16'h00aa);
      wr(1, c);
      nx();
      chk("ctl_busy", ctl_o, c);
      load(6'h00, 24'h000000, 1'b0);
      for (int i = 0; i < n; i++) begin
         chk("fl_req", fl_req_o, 1'b1);
         chk("fl_op", fl_op_o, (c[1:0] == 2'h2) ? FL_ERASE : FL_PROG);
         chk("fl_addr", fl_addr_o, b + i[15:0]);
         if (c[1:0] != 2'h2) chk("fl_wdata", fl_wdata_o, lat[b[5:0] + i[5:0]]);
         fl_done_i = 1;
         nx();
         fl_done_i = 0;
         nx();
      end
      chk("ctl_done", ctl_o, c & 16'h7fff);
      chk("stall_done", stall_o, 1'b0);
   endtask
   task automatic t_row();
      tblptr_i = 16'h0123;
      for (int i = 63; i >= 0; i--) load(i[5:0], 24'ha50000 | i[23:0], 1'b1);
      load(6'h05, 24'hffffff, 1'b1);
      load(6'h05, 24'h123456, 1'b1);
      run(16'h8001, 16'h0123, 16'h0100, 64);
      $display("test row done");
   endtask
   task automatic t_word();
      load(6'h02, 24'h0c0ffe, 1'b1);
      run(16'h8003, 16'h0042, 16'h0042, 1);
      $display("test word done");
   endtask
   task automatic t_erase();
      run(16'h8002, 16'h0abc, 16'h0a00, 1);
      run(16'h8002, 16'h0000, 16'h0000, 1);
      $display("test erase done");
   endtask
   // reset in mid-operation drops the stall and request; a keyless start after it is refused
   task automatic t_reset();
      wr(0, 16'h0055);
      wr(0, 16'h00aa);
      wr(1, 16'h8002);
      chk("busy_pre", stall_o, 1'b1);
      rst_b_i = 0;
      nx();
      chk("ctl_rst", ctl_o, 16'h0001);
      chk("stall_rst", stall_o, 1'b0);
      chk("req_rst", fl_req_o, 1'b0);
      rst_b_i = 1;
      nx();
      wr(1, 16'h8002);
      nx();
      chk("no_start_rst", stall_o, 1'b0);
      chk("op_rst", ctl_o, 16'h0002);
      $display("test reset done");
   endtask
   task automatic t_refuse();
      for (int k = 0; k < 4; k++) begin
         if (k > 0) wr(0, 16'h0055);
         if (k == 1) wr(2, 16'h0000);
         if (k == 2) load(6'h01, 24'hffffff, 1'b1);
         if (k > 0) wr(0, (k == 3) ? 16'h00a5 : 16'h00aa);
         wr(1, 16'h8001);
         nx();
         chk("no_start", stall_o, 1'b0);
      end
      wr(1, 16'h0002);
      nx();
      chk("op_readback", ctl_o, 16'h0002);
      $display("test refuse done");
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) nx();
      rst_b_i = 1;
      nx();
      chk("ctl_reset", ctl_o, 16'h0001);
      chk("stall_reset", stall_o, 1'b0);
      t_row();
      t_word();
      t_refuse();
      t_erase();
      t_reset();
      results();
   end
endmodule

// *** verification/flash_seq_monitor.sv ***
// Purpose: port checker for the flash sequencer
// Assumes: one clock, active low async reset
// Notes: key state is hidden, so a start is tied to the write before it
`timescale 1ns/1ps
module flash_seq_monitor
   import flash_seq_pkg::*;
#(parameter int ADDR_W = 16) (
   // inputs
   input wire logic clk_i, rst_b_i, tw_valid_i, ctl_wr_i, fl_done_i,
   input wire logic [CTL_W-1:0] ctl_data_i,
   // outputs
   input wire logic [CTL_W-1:0] ctl_o,
   input wire logic stall_o, tw_ack_o, fl_req_o,
   input wire logic [1:0] fl_op_o,
   input wire logic [ADDR_W-1:0] fl_addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_ack_one_cycle: assert property (tw_valid_i && !stall_o |=> tw_ack_o)
      else $error("latch load not acknowledged");
   chk_busy_no_ack: assert property (stall_o && tw_valid_i |=> !tw_ack_o)
      else $error("latch load taken while busy");
   chk_start_cause: assert property ($rose(stall_o) |-> $past(ctl_wr_i) && $past(ctl_data_i[15]))
      else $error("operation started without a start write");
   chk_start_shows: assert property ($rose(stall_o) |-> fl_req_o && ctl_o[15])
      else $error("start bit or request missing at start");
   chk_erase_align: assert property (fl_req_o && fl_op_o == FL_ERASE |-> fl_addr_o[8:0] == 9'h000)
      else $error("erase address not block aligned");
   chk_req_stalls: assert property (fl_req_o |-> stall_o && ctl_o[15])
      else $error("array busy without stall");
   chk_erase_ends: assert property (fl_req_o && fl_op_o == FL_ERASE && fl_done_i |=> !stall_o && !ctl_o[15])
      else $error("start bit not cleared after erase");
   chk_addr_stands: assert property (fl_req_o && !fl_done_i |=> fl_req_o && $stable(fl_addr_o))
      else $error("array request moved before done");
   cover property ($rose(stall_o));
   cover property (fl_op_o == FL_ERASE && fl_done_i);
   cover property (stall_o && tw_valid_i);
endmodule
bind flash_self_program_sequencer flash_seq_monitor #(.ADDR_W(ADDR_W)) i_mon (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .tw_valid_i(tw_valid_i), .ctl_wr_i(ctl_wr_i),
   .fl_done_i(fl_done_i), .ctl_data_i(ctl_data_i), .ctl_o(ctl_o), .stall_o(stall_o),
   .tw_ack_o(tw_ack_o), .fl_req_o(fl_req_o), .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o));

// *** verilog/flash_self_program_sequencer.sv ***
// Purpose: run-time self-program sequencer: holding latches, unlock key, row/word program, erase
// Assumes: all inputs come from core logic on clk_i; flash array answers with a done pulse
// Notes: holding latches have no reset on purpose and may hold garbage until loaded
`timescale 1ns/1ps
module flash_self_program_sequencer
   import flash_seq_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // table write into holding latches
   input wire logic tw_valid_i,
   input wire logic [ADDR_W-1:0] tw_addr_i,
   input wire logic [WORD_W-1:0] tw_data_i,
   // control register and unlock key writes
   input wire logic ctl_wr_i,
   input wire logic [CTL_W-1:0] ctl_data_i,
   input wire logic key_wr_i,
   input wire logic [7:0] key_data_i,
   input wire logic other_wr_i,
   input wire logic [ADDR_W-1:0] tblptr_i,
   // status toward the core
   output logic [CTL_W-1:0] ctl_o,
   output logic stall_o,
   output logic tw_ack_o,
   // flash array side
   output logic fl_req_o,
   output logic [1:0] fl_op_o,
   output logic [ADDR_W-1:0] fl_addr_o,
   output logic [WORD_W-1:0] fl_wdata_o,
   input wire logic fl_done_i
);

   function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a, input int sh);
      logic [ADDR_W-1:0] mask;
      mask = ~((ADDR_W'(1) << sh) - ADDR_W'(1));
      return a & mask;
   endfunction

   // unknown op codes are refused rather than guessed at
   function automatic logic known_op(input logic [CTL_OP_W-1:0] op);
      return (op == OP_WORD) || (op == OP_ROW) || (op == OP_ERASE);
   endfunction

   logic [WORD_W-1:0] latch_q [ROW_WORDS];
   seq_state_t state_q;
   key_state_t key_q;
   logic busy_q;
   logic [CTL_OP_W-1:0] op_q;
   logic [IDX_W-1:0] idx_q;
   logic [CNT_W-1:0] cnt_q;
   logic fl_req_q;
   logic [1:0] fl_op_q;
   logic [ADDR_W-1:0] fl_addr_q;
   logic [WORD_W-1:0] fl_wdata_q;
   logic tw_ack_q;
   logic [CTL_OP_W-1:0] wr_op;
   logic start_req;
   logic op_ok;
   logic go;
   logic tw_take;

   assign wr_op = ctl_data_i[CTL_OP_LSB +: CTL_OP_W];
   assign start_req = ctl_wr_i && ctl_data_i[CTL_START_BIT];
   assign op_ok = known_op(wr_op);
   // loads during an operation are dropped; the core is stalled then anyway
   assign tw_take = tw_valid_i && !busy_q;
   // only an armed key lets the start through
   assign go = start_req && op_ok && (key_q == KEY_ARMED) && !busy_q;

   // holding latches: no reset, so unloaded entries stay unknown
   always_ff @(posedge clk_i) begin
      if (tw_take) begin
         latch_q[tw_addr_i[IDX_W-1:0]] <= tw_data_i;
      end
   end

   // a latch load finishes in one clock and never touches the array
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tw_ack_q <= 1'b0;
      end else begin
         tw_ack_q <= tw_take;
      end
   end

   // unlock key tracker; any intervening write breaks the pair
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_q <= KEY_IDLE;
      end else if (key_wr_i) begin
         if (key_data_i == KEY_FIRST) begin
            key_q <= KEY_HALF;
         end else if (key_data_i == KEY_SECOND && key_q == KEY_HALF) begin
            key_q <= KEY_ARMED;
         end else begin
            key_q <= KEY_IDLE;
         end
      end else if (other_wr_i || ctl_wr_i || tw_valid_i) begin
         // a control write consumes the key whether or not it starts anything
         key_q <= KEY_IDLE;
      end
   end

   // control word: op select held, start bit cleared by hardware at finish
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_q <= OP_ROW;
      end else if (ctl_wr_i && !busy_q) begin
         op_q <= wr_op;
      end
   end

   // operation sequencer
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         idx_q <= '0;
         cnt_q <= CNT_ZERO;
         fl_req_q <= 1'b0;
         fl_op_q <= FL_NONE;
         fl_addr_q <= '0;
         fl_wdata_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (go) begin
                  busy_q <= 1'b1;
                  fl_req_q <= 1'b1;
                  if (wr_op == OP_ERASE) begin
                     state_q <= ST_ERASE;
                     fl_op_q <= FL_ERASE;
                     fl_addr_q <= align(tblptr_i, ERASE_SHIFT);
                  end else if (wr_op == OP_ROW) begin
                     state_q <= ST_PROG;
                     fl_op_q <= FL_PROG;
                     idx_q <= '0;
                     cnt_q <= CNT_ROW;
                     fl_addr_q <= align(tblptr_i, ROW_SHIFT);
                     fl_wdata_q <= latch_q[0];
                  end else begin
                     state_q <= ST_PROG;
                     fl_op_q <= FL_PROG;
                     idx_q <= tblptr_i[IDX_W-1:0];
                     cnt_q <= CNT_ONE;
                     fl_addr_q <= tblptr_i;
                     fl_wdata_q <= latch_q[tblptr_i[IDX_W-1:0]];
                  end
               end
            end
            ST_ERASE: begin
               if (fl_done_i) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  fl_req_q <= 1'b0;
                  fl_op_q <= FL_NONE;
               end
            end
            ST_PROG: begin
               if (fl_done_i) begin
                  if (cnt_q == CNT_ONE) begin
                     // last word of the row or the single word: release the core
                     state_q <= ST_IDLE;
                     busy_q <= 1'b0;
                     fl_req_q <= 1'b0;
                     fl_op_q <= FL_NONE;
                  end else begin
                     idx_q <= idx_q + IDX_W'(1);
                     cnt_q <= cnt_q - CNT_ONE;
                     fl_addr_q <= fl_addr_q + ADDR_W'(1);
                     fl_wdata_q <= latch_q[idx_q + IDX_W'(1)];
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
               fl_req_q <= 1'b0;
               fl_op_q <= FL_NONE;
            end
         endcase
      end
   end

   // readback and array outputs come straight from registers
   always_comb begin
      ctl_o = '0;
      ctl_o[CTL_START_BIT] = busy_q;
      ctl_o[CTL_OP_LSB +: CTL_OP_W] = op_q;
   end
   assign stall_o = busy_q;
   assign tw_ack_o = tw_ack_q;
   assign fl_req_o = fl_req_q;
   assign fl_op_o = fl_op_q;
   assign fl_addr_o = fl_addr_q;
   assign fl_wdata_o = fl_wdata_q;

endmodule

// *** verilog/flash_seq_pkg.sv ***
// Purpose: shared constants for the flash self-program sequencer
// Assumes: addresses are instruction-word indices, one word = 24 bits = 3 bytes
// Notes: op codes and control bit positions other than the start bit are local choices
package flash_seq_pkg;
   // array geometry
   localparam int WORD_W = 24;
   localparam int WORD_BYTES = 3;
   localparam int ROW_WORDS = 64;
   localparam int ROW_BYTES = ROW_WORDS * WORD_BYTES;
   localparam int ERASE_ROWS = 8;
   localparam int ERASE_WORDS = ROW_WORDS * ERASE_ROWS;
   localparam int ERASE_BYTES = ERASE_WORDS * WORD_BYTES;
   localparam int ROW_SHIFT = 6;
   localparam int ERASE_SHIFT = 9;
   localparam int IDX_W = 6;
   localparam int CNT_W = 7;
   // unlock key
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // control word layout
   localparam int CTL_W = 16;
   localparam int CTL_START_BIT = 15;
   localparam int CTL_OP_LSB = 0;
   localparam int CTL_OP_W = 4;
   localparam logic [3:0] OP_WORD = 4'h3;
   localparam logic [3:0] OP_ROW = 4'h1;
   localparam logic [3:0] OP_ERASE = 4'h2;
   // operation issued to the flash array
   localparam logic [1:0] FL_NONE = 2'h0;
   localparam logic [1:0] FL_PROG = 2'h1;
   localparam logic [1:0] FL_ERASE = 2'h2;
   localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
   localparam logic [CNT_W-1:0] CNT_ROW = 7'h40;
   localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} seq_state_t;
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_t;
endpackage
